// ### common/tcsf_pkg.sv
// package of constants for the thermocouple status flag block
package tcsf_pkg;
    localparam int          TCSF_RAW_W       = 24;
    localparam int          TCSF_ADC_W       = 18;
    localparam int          TCSF_TEMP_W      = 16;
    localparam int          TCSF_NALERT      = 4;
    // register addresses (device register pointer values, chosen)
    localparam logic [7:0]  TCSF_ADDR_STATUS = 8'h04;
    localparam logic [7:0]  TCSF_ADDR_RAW    = 8'h03;
    // status field positions
    localparam int          TCSF_BIT_BURST   = 7;
    localparam int          TCSF_BIT_UPDATE  = 6;
    localparam int          TCSF_BIT_SHORT   = 5;
    localparam int          TCSF_BIT_RANGE   = 4;
    // reset values
    localparam logic [7:0]  TCSF_STATUS_RST  = 8'h00;
    localparam logic [23:0] TCSF_RAW_RST     = 24'h000000;
    localparam logic [15:0] TCSF_TEMP_RST    = 16'h0000;
    localparam logic [1:0]  TCSF_SYNC_RST    = 2'h0;
endpackage

// ### core/tcsf_alert_cmp.sv
// one alert comparator: registered flag while selected temperature exceeds limit
module tcsf_alert_cmp
    import tcsf_pkg::*;
#(
    parameter int W = 16
) (
    // clock and reset
    input  wire logic         clk_i,
    input  wire logic         rst_n_i,
    // compare inputs
    input  wire logic         sel_cold_i,
    input  wire logic [W-1:0] hot_i,
    input  wire logic [W-1:0] cold_i,
    input  wire logic [W-1:0] limit_i,
    // result
    output logic              above_o
);
    typedef struct packed {
        logic above;
    } tcsf_cmp_st_t;

    tcsf_cmp_st_t s_q;
    tcsf_cmp_st_t s_d;
    logic [W-1:0] sel_temp;

    // signed compare of the chosen junction temperature
    always_comb begin
        sel_temp = sel_cold_i ? cold_i : hot_i;
        s_d.above = $signed(sel_temp) > $signed(limit_i);
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign above_o = s_q.above;

    property p_alert_follows;
        @(posedge clk_i) disable iff (!rst_n_i)
        1'b1 |=> (above_o == $past($signed(sel_cold_i ? cold_i : hot_i) > $signed(limit_i)));
    endproperty
    a_alert_follows: assert property (p_alert_follows) else $error("alert flag missed exceedance");
endmodule

// ### core/tcsf_status.sv
// raw converter result and sensor status flag registers
module tcsf_status
    import tcsf_pkg::*;
#(
    parameter bit FAULT_DETECT = 1'b1,
    parameter int NALERT       = TCSF_NALERT
) (
    // clock and reset
    input  wire logic                           clk_i,
    input  wire logic                           rst_n_i,
    // converter events
    input  wire logic                           conv_done_i,
    input  wire logic                           burst_done_i,
    input  wire logic [TCSF_ADC_W-1:0]          adc_sample_i,
    input  wire logic [TCSF_TEMP_W-1:0]         hot_calc_i,
    input  wire logic [TCSF_TEMP_W-1:0]         diff_calc_i,
    input  wire logic [TCSF_TEMP_W-1:0]         cold_calc_i,
    // fault and range conditions
    input  wire logic                           emf_over_range_i,
    input  wire logic                           temp_over_range_i,
    input  wire logic                           short_detect_i,
    input  wire logic                           open_detect_i,
    // alert settings
    input  wire logic [NALERT-1:0]              alert_sel_cold_i,
    input  wire logic [NALERT*TCSF_TEMP_W-1:0]  alert_limit_i,
    // register access port
    input  wire logic                           wr_en_i,
    input  wire logic [7:0]                     wr_addr_i,
    input  wire logic [7:0]                     wr_data_i,
    // register contents
    output logic [TCSF_RAW_W-1:0]               raw_result_o,
    output logic [7:0]                          status_o,
    output logic [TCSF_TEMP_W-1:0]              hot_junction_temp_o,
    output logic [TCSF_TEMP_W-1:0]              diff_temp_o,
    output logic [TCSF_TEMP_W-1:0]              cold_junction_temp_o
);
    typedef struct packed {
        logic [TCSF_RAW_W-1:0]   raw;
        logic                    burst;
        logic                    update;
        logic                    short_flag;
        logic                    range_flag;
        logic [TCSF_TEMP_W-1:0]  hot;
        logic [TCSF_TEMP_W-1:0]  diff;
        logic [TCSF_TEMP_W-1:0]  cold;
    } tcsf_state_t;

    tcsf_state_t       s_q;
    tcsf_state_t       s_d;
    logic [1:0]        rst_sync_q;
    logic              rst_n;
    logic              out_of_range;
    logic              status_wr;
    logic [NALERT-1:0] alert_above;

    // reset release through two flops, kept apart from the state so each has one writer
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rst_sync_q <= TCSF_SYNC_RST;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    // one comparator per alert
    genvar g;
    generate
        for (g = 0; g < NALERT; g++) begin : g_alert
            tcsf_alert_cmp #(.W(TCSF_TEMP_W)) u_cmp (
                .clk_i      (clk_i),
                .rst_n_i    (rst_n),
                .sel_cold_i (alert_sel_cold_i[g]),
                .hot_i      (s_q.hot),
                .cold_i     (s_q.cold),
                .limit_i    (alert_limit_i[g*TCSF_TEMP_W +: TCSF_TEMP_W]),
                .above_o    (alert_above[g])
            );
        end
    endgenerate

    assign out_of_range = emf_over_range_i | temp_over_range_i | (FAULT_DETECT & open_detect_i);
    assign status_wr    = wr_en_i && (wr_addr_i == TCSF_ADDR_STATUS);

    // next state of all flags and data
    always_comb begin
        s_d = s_q;
        // writing zero clears, writing one is ignored; a set in the same cycle wins
        if (status_wr && !wr_data_i[TCSF_BIT_BURST]) begin
            s_d.burst = 1'b0;
        end
        if (status_wr && !wr_data_i[TCSF_BIT_UPDATE]) begin
            s_d.update = 1'b0;
        end
        if (burst_done_i) begin
            s_d.burst = 1'b1;
        end
        if (conv_done_i) begin
            s_d.update = 1'b1;
            s_d.cold = cold_calc_i;
            if (!emf_over_range_i) begin
                s_d.hot = hot_calc_i;
                s_d.diff = diff_calc_i;
                // sign-extend the 18-bit sample so bits 23-18 follow the sign
                s_d.raw = {{(TCSF_RAW_W-TCSF_ADC_W){adc_sample_i[TCSF_ADC_W-1]}}, adc_sample_i};
            end
        end
        s_d.short_flag = FAULT_DETECT ? short_detect_i : 1'b0;
        s_d.range_flag = out_of_range;
    end

    // state register; read-only fields never take write data
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            s_q.raw        <= TCSF_RAW_RST;
            s_q.burst      <= TCSF_STATUS_RST[TCSF_BIT_BURST];
            s_q.update     <= TCSF_STATUS_RST[TCSF_BIT_UPDATE];
            s_q.short_flag <= TCSF_STATUS_RST[TCSF_BIT_SHORT];
            s_q.range_flag <= TCSF_STATUS_RST[TCSF_BIT_RANGE];
            s_q.hot        <= TCSF_TEMP_RST;
            s_q.diff       <= TCSF_TEMP_RST;
            s_q.cold       <= TCSF_TEMP_RST;
        end else begin
            s_q.raw        <= s_d.raw;
            s_q.burst      <= s_d.burst;
            s_q.update     <= s_d.update;
            s_q.short_flag <= s_d.short_flag;
            s_q.range_flag <= s_d.range_flag;
            s_q.hot        <= s_d.hot;
            s_q.diff       <= s_d.diff;
            s_q.cold       <= s_d.cold;
        end
    end

    // register views
    assign raw_result_o         = s_q.raw;
    assign status_o             = {s_q.burst, s_q.update, s_q.short_flag, s_q.range_flag, alert_above};
    assign hot_junction_temp_o  = s_q.hot;
    assign diff_temp_o          = s_q.diff;
    assign cold_junction_temp_o = s_q.cold;

    property p_raw_sign;
        @(posedge clk_i) disable iff (!rst_n)
        (raw_result_o[23:18] == {6{raw_result_o[17]}});
    endproperty
    a_raw_sign: assert property (p_raw_sign) else $error("raw sign bits disagree");

    property p_burst_set;
        @(posedge clk_i) disable iff (!rst_n)
        burst_done_i |=> status_o[TCSF_BIT_BURST];
    endproperty
    a_burst_set: assert property (p_burst_set) else $error("burst flag not set");

    property p_burst_hold;
        @(posedge clk_i) disable iff (!rst_n)
        (!status_o[TCSF_BIT_BURST] && !burst_done_i) |=> !status_o[TCSF_BIT_BURST];
    endproperty
    a_burst_hold: assert property (p_burst_hold) else $error("burst flag set without burst");

    property p_update_set;
        @(posedge clk_i) disable iff (!rst_n)
        conv_done_i |=> status_o[TCSF_BIT_UPDATE];
    endproperty
    a_update_set: assert property (p_update_set) else $error("update flag not set");

    property p_update_clear;
        @(posedge clk_i) disable iff (!rst_n)
        (status_wr && !wr_data_i[TCSF_BIT_UPDATE] && !conv_done_i) |=> !status_o[TCSF_BIT_UPDATE];
    endproperty
    a_update_clear: assert property (p_update_clear) else $error("update flag not cleared");

    property p_short_bit;
        @(posedge clk_i) disable iff (!rst_n)
        1'b1 |=> (status_o[TCSF_BIT_SHORT] == (FAULT_DETECT && $past(short_detect_i)));
    endproperty
    a_short_bit: assert property (p_short_bit) else $error("short bit wrong");

    property p_range_bit;
        @(posedge clk_i) disable iff (!rst_n)
        1'b1 |=> (status_o[TCSF_BIT_RANGE] == $past(out_of_range));
    endproperty
    a_range_bit: assert property (p_range_bit) else $error("range bit wrong");

    property p_hot_hold;
        @(posedge clk_i) disable iff (!rst_n)
        (conv_done_i && emf_over_range_i) |=> (hot_junction_temp_o == $past(hot_junction_temp_o))
            && (cold_junction_temp_o == $past(cold_calc_i));
    endproperty
    a_hot_hold: assert property (p_hot_hold) else $error("over-range update wrong");

    property p_raw_stable;
        @(posedge clk_i) disable iff (!rst_n)
        (wr_en_i && !conv_done_i) |=> $stable(raw_result_o);
    endproperty
    a_raw_stable: assert property (p_raw_stable) else $error("write changed raw result");
endmodule

// ### verif/tcsf_host_model.sv
// host controller model that writes the device registers through the access port
module tcsf_host_model
    import tcsf_pkg::*;
(
    // clock
    input  wire logic clk_i,
    // register write port
    output logic       wr_en_o,
    output logic [7:0] wr_addr_o,
    output logic [7:0] wr_data_o
);
    timeunit 1ns;
    timeprecision 1ps;

    // idle port at time zero
    initial begin
        wr_en_o   = 1'b0;
        wr_addr_o = 8'h00;
        wr_data_o = 8'h00;
    end

    // one write, held across exactly one sampling edge
    task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
        @(posedge clk_i);
        #1;
        wr_en_o   = 1'b1;
        wr_addr_o = addr;
        wr_data_o = data;
        @(posedge clk_i);
        #1;
        wr_en_o   = 1'b0;
        wr_addr_o = ~addr; // released lines no longer show the address
        wr_data_o = ~data;
    endtask

    // clears both event flags before polling them again
    task automatic clear_flags();
        write_reg(TCSF_ADDR_STATUS, 8'h00);
    endtask
endmodule

// ### verif/tb_top.sv
// self-checking bench for the status flag and raw result registers
module tb_top
    import tcsf_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic        clk_i = 1'b0, rst_n_i = 1'b0, conv_done_i = 1'b0, burst_done_i = 1'b0;
    logic [17:0] adc_sample_i = 18'h00000;
    logic [15:0] hot_calc_i = 16'h0000, diff_calc_i = 16'h0000, cold_calc_i = 16'h0000;
    logic        emf_over_range_i = 1'b0, temp_over_range_i = 1'b0, short_detect_i = 1'b0, open_detect_i = 1'b0;
    logic [3:0]  alert_sel_cold_i = 4'hC;
    logic [63:0] alert_limit_i = {16'h0050, 16'h0010, 16'h0300, 16'h0100};
    logic        wr_en_i;
    logic [7:0]  wr_addr_i, wr_data_i, status_o, status_nf;
    logic [23:0] raw_result_o;
    logic [15:0] hot_junction_temp_o, diff_temp_o, cold_junction_temp_o;
    int          n_fail = 0, check_count = 0;

    // clock at 125 MHz
    always #4 clk_i = ~clk_i;

    tcsf_host_model i_tcsf_host_model (.clk_i, .wr_en_o(wr_en_i), .wr_addr_o(wr_addr_i), .wr_data_o(wr_data_i));
    tcsf_status i_tcsf_status (.clk_i, .rst_n_i, .conv_done_i, .burst_done_i, .adc_sample_i, .hot_calc_i,
        .diff_calc_i, .cold_calc_i, .emf_over_range_i, .temp_over_range_i, .short_detect_i, .open_detect_i,
        .alert_sel_cold_i, .alert_limit_i, .wr_en_i, .wr_addr_i, .wr_data_i, .raw_result_o, .status_o,
        .hot_junction_temp_o, .diff_temp_o, .cold_junction_temp_o);
    // variant without fault detection
    tcsf_status #(.FAULT_DETECT(1'b0)) i_tcsf_status_nf (.clk_i, .rst_n_i, .conv_done_i, .burst_done_i,
        .adc_sample_i, .hot_calc_i, .diff_calc_i, .cold_calc_i, .emf_over_range_i, .temp_over_range_i,
        .short_detect_i, .open_detect_i, .alert_sel_cold_i, .alert_limit_i, .wr_en_i, .wr_addr_i, .wr_data_i,
        .raw_result_o(), .status_o(status_nf), .hot_junction_temp_o(), .diff_temp_o(), .cold_junction_temp_o());

    // compare and count
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // wait edges, then let the updates settle
    task automatic edges(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask

    // one cycle event pulse with new conversion data
    task automatic pulse(input logic burst, input logic [17:0] a, input logic [15:0] h, d, c);
        edges(1);
        adc_sample_i = a;
        hot_calc_i   = h;
        diff_calc_i  = d;
        cold_calc_i  = c;
        if (burst) begin
            burst_done_i = 1'b1;
        end else begin
            conv_done_i = 1'b1;
        end
        edges(1);
        burst_done_i = 1'b0;
        conv_done_i  = 1'b0;
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // watchdog
    initial begin
        #20000;
        n_fail++;
        finish_test();
    end

    // test sequence
    initial begin
        edges(8);
        rst_n_i = 1'b1;
        edges(4);
        chk(24'(status_o), 24'h00);
        chk(raw_result_o, 24'h000000);
        $display("reset test done");
        pulse(1'b0, 18'h3FFF0, 16'h0200, 16'h01B0, 16'h0050);
        chk(raw_result_o, 24'hFFFFF0);
        chk(24'(status_o[6]), 24'h1);
        edges(1);
        chk(24'(status_o), 24'h45);
        pulse(1'b1, 18'h3FFF0, 16'h0200, 16'h01B0, 16'h0050);
        chk(24'(status_o), 24'hC5);
        i_tcsf_host_model.clear_flags();
        chk(24'(status_o), 24'h05);
        i_tcsf_host_model.write_reg(TCSF_ADDR_STATUS, 8'hFF);
        chk(24'(status_o), 24'h05);
        i_tcsf_host_model.write_reg(TCSF_ADDR_RAW, 8'h00);
        chk(raw_result_o, 24'hFFFFF0);
        pulse(1'b0, 18'h1FFFF, 16'h0200, 16'h01B0, 16'h0050);
        chk(raw_result_o, 24'h01FFFF);
        chk(24'(status_o), 24'h45);
        // clear and burst end in one cycle: the set wins, the update flag clears
        fork
            i_tcsf_host_model.clear_flags();
            pulse(1'b1, 18'h1FFFF, 16'h0200, 16'h01B0, 16'h0050);
        join
        chk(24'(status_o), 24'h85);
        $display("flag test done");
        emf_over_range_i = 1'b1;
        pulse(1'b0, 18'h00001, 16'h0400, 16'h0111, 16'h0060);
        edges(1);
        chk(24'(hot_junction_temp_o), 24'h0200);
        chk(24'(diff_temp_o), 24'h01B0);
        chk(24'(cold_junction_temp_o), 24'h0060);
        chk(raw_result_o, 24'h01FFFF);
        chk(24'(status_o), 24'hDD);
        emf_over_range_i = 1'b0;
        $display("range test done");
        for (int i = 0; i < 3; i++) begin
            {short_detect_i, open_detect_i, temp_over_range_i} = 3'h4 >> i;
            edges(2);
            chk(24'(status_o[5:4]), (i == 0) ? 24'h2 : 24'h1);
            chk(24'(status_nf[5:4]), (i == 2) ? 24'h1 : 24'h0);
        end
        {short_detect_i, open_detect_i, temp_over_range_i} = 3'h0;
        edges(2);
        chk(24'(status_o[5:4]), 24'h0);
        $display("fault test done");
        finish_test();
    end
endmodule
